/* File: flash_bus_if.sv */
// Carries single bus cycle requests from the sequencer to the cycle engine.
// Assumes both ends run on one clock.
interface flash_bus_if;
  logic        req;    // Start one bus cycle, pulse
  logic        wr;     // 1 write, 0 read
  logic [18:0] addr;   // Cycle address
  logic [7:0]  wdata;  // Write data
  logic        done;   // Cycle finished, pulse
  logic [7:0]  rdata;  // Captured read data
  modport master (output req, output wr, output addr, output wdata,
                  input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata,
                  output done, output rdata);
endinterface

/* File: flash_cycle_engine.sv */
// Bus cycle engine: shapes one read or write strobe cycle on the flash pins.
// Assumes data pins are synchronised before they reach DQ_SYNC.
module flash_cycle_engine (
  input  wire logic  clk,
  input  wire logic  nrst,
  flash_bus_if.engine bus,
  input  wire logic [7:0]  dq_sync,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [18:0]      addr,
  output logic [7:0]       dq_out,
  output logic             dq_oe
);
  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_SETUP = 2'b01,
    C_STRB  = 2'b10,
    C_HOLD  = 2'b11
  } cyc_t;
  cyc_t       state;        // Cycle phase
  logic [3:0] cnt;          // Phase counter
  logic       wr;           // Latched direction
  wire  [3:0] strobe_len = wr ? 4'(flash_host_pkg::WE_PULSE_CYC)
                              : 4'(flash_host_pkg::RD_ACCESS_CYC + 2);
  // Read waits two extra cycles for the pin synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= C_IDLE; cnt <= 4'h0; wr <= 1'b0; bus.done <= 1'b0;
      bus.rdata <= 8'h00; ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1;
      addr <= 19'h00000; dq_out <= 8'h00; dq_oe <= 1'b0;
    end else begin
      bus.done <= 1'b0;
      unique case (state)
        C_IDLE: if (bus.req) begin
          // Address and data settle before any strobe falls
          wr <= bus.wr; addr <= bus.addr; dq_out <= bus.wdata;
          dq_oe <= bus.wr; ce_n <= 1'b0; cnt <= 4'h0; state <= C_SETUP;
        end
        C_SETUP: begin
          // Write holds OE high so the cycle is not inhibited
          if (wr) we_n <= 1'b0; else oe_n <= 1'b0;
          cnt <= 4'h1; state <= C_STRB;
        end
        C_STRB: if (cnt >= strobe_len) begin
          // Strobe rises: the flash latches write data here; read data is captured from dq_sync here
          we_n <= 1'b1; oe_n <= 1'b1; bus.rdata <= dq_sync; state <= C_HOLD; cnt <= 4'h0;
        end else cnt <= cnt + 4'h1;
        C_HOLD: begin
          // Deselect, release the bus and report completion in the same cycle
          ce_n <= 1'b1; dq_oe <= 1'b0; bus.done <= 1'b1; state <= C_IDLE;
        end
      endcase
    end
  end
  // Write strobe held low long enough to pass the glitch filter
  we_width_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(we_n) |-> !we_n [*3]) else $error("write strobe too short");
  no_oe_write_a: assert property (@(posedge clk) disable iff (!nrst)
    !we_n |-> oe_n && !ce_n && dq_oe) else $error("write cycle with OE low");
  read_release_a: assert property (@(posedge clk) disable iff (!nrst)
    !oe_n |-> !dq_oe) else $error("host drives bus during read");
endmodule

/* File: flash_host_ctrl.sv */
// Host controller for an asynchronous byte-wide flash with boot lockout.
// Assumes a user that issues one operation at a time and a flash on the pins.
// Overview of operation
// - Chip erase is a six-write sequence
// - Byte program is four writes
// - Six-write lockout sequence is permanent
// - Identification mode is left only by a separate ID exit operation
// - Host polls until true data appears; the code also stops polling at the timeout limit and reports ERROR
// - Unlock AA/5555, 55/2AAA, then command
// - ID entry 90, exit F0
module flash_host_ctrl (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        START,      // Start an operation, pulse
  input  wire logic [2:0]  OP,         // flash_host_pkg::op_t code
  input  wire logic [18:0] ADDRESS,    // Target byte address
  input  wire logic [7:0]  WDATA,      // Program data
  output logic             BUSY,       // Operation in progress
  output logic             DONE,       // Operation finished, pulse
  output logic             ERROR,      // Timeout or refused, with DONE
  output logic [7:0]       RDATA,      // Read result
  output logic             CE_N,       // Flash chip enable
  output logic             OE_N,       // Flash output enable
  output logic             WE_N,       // Flash write enable
  output logic [18:0]      BYTE_ADDRESS, // Flash address
  input  wire logic [7:0]  DATA_LINES_I, // Flash data in
  output logic [7:0]       DATA_LINES_O, // Flash data out
  output logic             DATA_LINES_OE // High while host drives
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,   // Waiting for a request
    S_SEQ  = 3'b001,   // Issuing command writes
    S_POLL = 3'b010,   // Polling for completion
    S_READ = 3'b011,   // Single read
    S_END  = 3'b100    // Report result
  } state_t;
  state_t      state;          // Sequencer state
  logic [2:0]  step;           // Write index in sequence
  logic [2:0]  op;             // Latched operation
  logic [18:0] tgt_addr;       // Latched address
  logic [7:0]  tgt_data;       // Latched data
  logic [7:0]  dq_meta;        // First synchroniser stage
  logic [7:0]  dq_sync;        // Second synchroniser stage
  logic        issued;         // Cycle request outstanding
  logic        have_prev;      // A previous poll read exists
  logic [7:0]  prev;           // Previous poll read
  logic [38:0] timer;          // Operation timeout counter
  logic        fail;           // Timeout flag
  flash_bus_if bus ();
  // Two-flop synchroniser on the data pins
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dq_meta <= 8'h00; dq_sync <= 8'h00;
    end else begin
      dq_meta <= DATA_LINES_I; dq_sync <= dq_meta;
    end
  end
  flash_cycle_engine u_eng (
    .clk     (CLK),
    .nrst    (NRST),
    .bus     (bus),
    .dq_sync (dq_sync),
    .ce_n    (CE_N),
    .oe_n    (OE_N),
    .we_n    (WE_N),
    .addr    (BYTE_ADDRESS),
    .dq_out  (DATA_LINES_O),
    .dq_oe   (DATA_LINES_OE)
  );
  // Sequence length per operation
  wire [2:0] seq_len = (op == flash_host_pkg::OP_PROGRAM) ? 3'd4 :
                       (op == flash_host_pkg::OP_ERASE ||
                        op == flash_host_pkg::OP_LOCKOUT) ? 3'd6 :
                       (op == flash_host_pkg::OP_ID_EXIT) ? 3'd1 : 3'd3;
  // Command write table: unlock pair, command, target or second unlock
  logic [18:0] seq_addr;
  logic [7:0]  seq_data;
  always_comb begin
    seq_addr = flash_host_pkg::UNLOCK_ADDR1;
    seq_data = flash_host_pkg::UNLOCK_DATA1;
    unique case (step)
      3'd0: if (op == flash_host_pkg::OP_ID_EXIT) seq_data = flash_host_pkg::CMD_ID_EXIT;
      3'd1, 3'd4: begin
        seq_addr = flash_host_pkg::UNLOCK_ADDR2; seq_data = flash_host_pkg::UNLOCK_DATA2;
      end
      3'd2: seq_data = (op == flash_host_pkg::OP_PROGRAM) ? flash_host_pkg::CMD_PROGRAM :
                       (op == flash_host_pkg::OP_ID_READ) ? flash_host_pkg::CMD_ID_ENTRY :
                                                            flash_host_pkg::CMD_SETUP;
      3'd3: if (op == flash_host_pkg::OP_PROGRAM) begin
        seq_addr = tgt_addr; seq_data = tgt_data;
      end
      3'd5: seq_data = (op == flash_host_pkg::OP_LOCKOUT) ? flash_host_pkg::CMD_LOCKOUT
                                                          : flash_host_pkg::CMD_ERASE;
      default: seq_data = flash_host_pkg::UNLOCK_DATA1;
    endcase
  end
  // Completion: toggle bit still; polling bit true for programs
  wire toggle_still = have_prev &&
    (prev[flash_host_pkg::TOGGLE_BIT] == bus.rdata[flash_host_pkg::TOGGLE_BIT]);
  wire poll_true = (op != flash_host_pkg::OP_PROGRAM) ||
    (bus.rdata[flash_host_pkg::POLL_BIT] == tgt_data[flash_host_pkg::POLL_BIT]);
  wire finished = toggle_still && poll_true;
  wire [38:0] limit = (op == flash_host_pkg::OP_PROGRAM)
    ? 39'(flash_host_pkg::PROG_TIMEOUT_CYC)
    : 39'(flash_host_pkg::ERASE_TIMEOUT_CYC);
  // Poll gives up at the limit; an open read still finishes so its done is not stale
  wire timed_out = (timer >= limit);
  wire needs_poll = (op == flash_host_pkg::OP_PROGRAM || op == flash_host_pkg::OP_ERASE ||
                     op == flash_host_pkg::OP_LOCKOUT);
  wire last_write = (step == seq_len - 3'd1);
  // Read target: the latched address for every read
  wire [18:0] rd_addr = tgt_addr;  // Polls, array and ID reads use the latched address
  // Bus request drive
  assign bus.req   = !issued && (state == S_SEQ || (state == S_POLL && !timed_out) ||
                                 state == S_READ);
  assign bus.wr    = (state == S_SEQ);
  assign bus.addr  = (state == S_SEQ) ? seq_addr : rd_addr;
  assign bus.wdata = seq_data;
  // Operation sequencer; no new command until the last one finished
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= S_IDLE; step <= 3'd0; op <= 3'd0; tgt_addr <= 19'h00000;
      tgt_data <= 8'h00; issued <= 1'b0; have_prev <= 1'b0; prev <= 8'h00;
      timer <= 39'h0; fail <= 1'b0; BUSY <= 1'b0; DONE <= 1'b0; ERROR <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      DONE <= 1'b0;
      if (bus.req) issued <= 1'b1;
      if (bus.done) issued <= 1'b0;
      unique case (state)
        S_IDLE: if (START) begin
          op <= OP; tgt_addr <= ADDRESS; tgt_data <= WDATA; step <= 3'd0;
          have_prev <= 1'b0; timer <= 39'h0; fail <= 1'b0; BUSY <= 1'b1;
          state <= (OP == flash_host_pkg::OP_READ) ? S_READ : S_SEQ;
        end
        S_SEQ: if (bus.done) begin
          step <= step + 3'd1;
          if (last_write) state <= needs_poll ? S_POLL : (op == flash_host_pkg::OP_ID_READ)
                                                         ? S_READ : S_END;
        end
        S_POLL: begin
          timer <= timer + 39'h1;
          if (bus.done) begin
            prev <= bus.rdata; have_prev <= 1'b1;
            if (finished) state <= S_END;
          end else if (timed_out && !issued) begin
            fail <= 1'b1; state <= S_END;
          end
        end
        S_READ: if (bus.done) begin
          RDATA <= bus.rdata; state <= S_END;
        end
        S_END: begin
          BUSY <= 1'b0; DONE <= 1'b1; ERROR <= fail; state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // A program sequence is exactly four writes ending at the target
  prog_target_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_SEQ && op == flash_host_pkg::OP_PROGRAM && step == 3'd3 && bus.req
    |-> bus.addr == tgt_addr && bus.wdata == tgt_data) else $error("bad program write");
  unlock_first_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_SEQ && step == 3'd0 && op != flash_host_pkg::OP_ID_EXIT && bus.req
    |-> bus.addr == flash_host_pkg::UNLOCK_ADDR1 && bus.wdata == flash_host_pkg::UNLOCK_DATA1)
    else $error("bad first unlock write");
  unlock_second_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_SEQ && step == 3'd1 && bus.req
    |-> bus.addr == flash_host_pkg::UNLOCK_ADDR2 && bus.wdata == flash_host_pkg::UNLOCK_DATA2)
    else $error("bad second unlock write");
  erase_final_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_SEQ && step == 3'd5 && op == flash_host_pkg::OP_ERASE && bus.req
    |-> bus.wdata == flash_host_pkg::CMD_ERASE) else $error("bad erase command");
  lockout_final_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_SEQ && step == 3'd5 && op == flash_host_pkg::OP_LOCKOUT && bus.req
    |-> bus.wdata == flash_host_pkg::CMD_LOCKOUT) else $error("bad lockout command");
  idexit_one_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_SEQ && op == flash_host_pkg::OP_ID_EXIT && bus.req
    |-> bus.wdata == flash_host_pkg::CMD_ID_EXIT) else $error("bad exit write");
  // A start is taken only from idle; a start while busy leaves the latched job alone
  start_taken_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_IDLE && START |=> BUSY) else $error("start not taken");
  refuse_busy_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUSY && START |=> $stable(op) && $stable(tgt_addr))
    else $error("start accepted while busy");
  busy_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUSY && !DONE |=> BUSY || DONE) else $error("busy dropped without done");
  done_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
    DONE |=> !DONE && !BUSY) else $error("done not a single pulse");
  write_sel_a: assert property (@(posedge CLK) disable iff (!NRST)
    !WE_N |-> !CE_N && OE_N) else $error("write without select");
  // Polling stops on true data, or at the limit once no read is open
  poll_end_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_POLL && bus.done && finished |=> state == S_END)
    else $error("poll did not stop");
  poll_timeout_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_POLL && timed_out && !issued |=> state == S_END && fail)
    else $error("poll limit not honoured");
  poll_quiet_a: assert property (@(posedge CLK) disable iff (!NRST)
    state == S_POLL && timed_out |-> !bus.req) else $error("read started after limit");
  // Main scenarios
  program_c: cover property (@(posedge CLK) state == S_POLL && op == 3'd1 ##[1:900] DONE);
  erase_c: cover property (@(posedge CLK) state == S_SEQ && op == 3'd2 && step == 3'd5);
  lockout_c: cover property (@(posedge CLK) state == S_SEQ && op == 3'd3 && step == 3'd5);
  timeout_c: cover property (@(posedge CLK) state == S_END && fail);
  idread_c: cover property (@(posedge CLK) state == S_READ && op == 3'd4);
endmodule

/* File: flash_host_pkg.sv */
// Constants shared by the parallel flash host controller and its bus cycle engine.
// Assumes a 40 MHz CLK and an asynchronous byte-wide flash on the far side.
package flash_host_pkg;
  localparam int          ADDR_W        = 19;        // Byte address width
  localparam int          DATA_W        = 8;         // Data line width
  localparam int          CLK_MHZ       = 40;        // CLK rate in MHz
  localparam int          CLK_NS        = 25;        // CLK period in ns
  // Bus cycle timing: low pulse far above the 15 ns glitch filter
  localparam int          WE_PULSE_NS   = 100;       // Write strobe low time, ns
  localparam int          WE_PULSE_CYC  = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RD_ACCESS_NS  = 150;       // Read access allowance, ns
  localparam int          RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SETUP_CYC     = 1;         // Address setup / recovery cycles
  // Operation timeouts
  localparam int          BYTE_PROGRAM_TIME_US = 50;     // Nominal byte program time
  localparam int          MAX_ERASE_TIME_S     = 10;     // Chip erase time bound
  localparam int          PROG_TIMEOUT_CYC = 4 * BYTE_PROGRAM_TIME_US * CLK_MHZ;
  localparam longint      ERASE_TIMEOUT_CYC = 64'(MAX_ERASE_TIME_S) * 1000000 * CLK_MHZ;
  // Command addresses and data
  localparam logic [18:0] UNLOCK_ADDR1  = 19'h05555; // First unlock address
  localparam logic [18:0] UNLOCK_ADDR2  = 19'h02aaa; // Second unlock address
  localparam logic [7:0]  UNLOCK_DATA1  = 8'haa;     // First unlock data
  localparam logic [7:0]  UNLOCK_DATA2  = 8'h55;     // Second unlock data
  localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;     // Byte program
  localparam logic [7:0]  CMD_SETUP     = 8'h80;     // Erase / lockout setup
  localparam logic [7:0]  CMD_ERASE     = 8'h10;     // Chip erase final
  localparam logic [7:0]  CMD_LOCKOUT   = 8'h40;     // Boot lockout final
  localparam logic [7:0]  CMD_ID_ENTRY  = 8'h90;     // Identification entry
  localparam logic [7:0]  CMD_ID_EXIT   = 8'hf0;     // Identification exit
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;     // Erased byte value
  localparam logic [18:0] BOOT_LAST     = 19'h03fff; // Last boot block address
  localparam logic [18:0] LOCK_STAT_ADDR = 19'h00002; // Lockout status in ID mode
  localparam int          POLL_BIT      = 7;         // Complement polling bit
  localparam int          TOGGLE_BIT    = 6;         // Toggle status bit
  localparam int          LOCK_BIT      = 0;         // Lockout status bit
  // Host operation codes
  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_PROGRAM = 3'b001,
    OP_ERASE   = 3'b010,
    OP_LOCKOUT = 3'b011,
    OP_ID_READ = 3'b100,
    OP_ID_EXIT = 3'b101
  } op_t;
endpackage

/* File: flash_model.sv */
// Behavioural byte-wide flash with command decoder, boot lockout and status polling.
// Assumes strobes from one bus master and a bench that resolves the shared data lines.
module flash_model #(
  parameter int          PROG_NS    = 50000,  // Internal byte program time
  parameter int          ERASE_NS   = 30000,  // Internal chip erase time, shortened
  parameter int          ACC_NS     = 55,     // Read access time
  parameter logic [7:0]  MAKER_CODE = 8'h3c,  // Arbitrary value
  parameter logic [7:0]  DEV_CODE   = 8'hc3   // Arbitrary value
) (
  input  wire logic        ce_n,      // Chip enable, active low
  input  wire logic        oe_n,      // Output enable, active low
  input  wire logic        we_n,      // Write enable, active low
  input  wire logic [18:0] addr,      // Byte address
  input  wire logic [7:0]  dq_in,     // Resolved data lines
  output logic [7:0]       dq_out,    // Value the flash puts out
  output logic             dq_oe,     // High while the flash drives
  output int               wr_count   // Accepted write strobes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:524287];  // Array contents
  logic        wr;              // Combined write strobe
  logic        rd;              // Combined read strobe
  logic        locked;          // Boot lockout state
  logic        id_mode;         // Identification mode
  logic        tog;             // Toggle status state
  logic        vld;             // Access time elapsed
  logic        low_vcc;         // Supply sense, held healthy here
  logic [18:0] la;              // Address latched at strobe fall
  logic [7:0]  ld;              // Last loaded byte
  logic [7:0]  rd_val;          // Byte of the current read
  int          st;              // Command decoder step
  time         t_fall;          // Strobe fall time
  time         busy_until;      // End of internal operation
  assign wr = !ce_n && !we_n && oe_n;  // no write with OE low or a strobe high
  assign rd = !ce_n && !oe_n && we_n;
  assign dq_oe = rd;
  // Released lines show the inverse of the last value
  assign dq_out = (rd && vld) ? rd_val : ~rd_val;
  // Erased array, unlocked, normal read state
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {locked, id_mode, tog, vld, low_vcc} = 5'h00;
    st = 0; busy_until = 0; wr_count = 0; rd_val = 8'h00; la = '0; ld = 8'hff; t_fall = 0;
  end
  // Address is taken when the later strobe falls
  always @(posedge wr) begin
    t_fall = $time;
    la = addr;
  end
  // Data is taken when the earlier strobe rises; short pulses are dropped
  always @(negedge wr) begin
    if ($time - t_fall >= 15) begin
      wr_count++;
      cmd(la, dq_in);
    end
  end
  // Command decoder
  task cmd(input logic [18:0] a, input logic [7:0] d);
    logic u1, u2, c;
    u1 = (a == 19'h05555) && (d == 8'haa);
    u2 = (a == 19'h02aaa) && (d == 8'h55);
    c = (a == 19'h05555);
    if ($time < busy_until) return;
    case (st)
      0: begin
        st = u1 ? 1 : 0;
        if (!u1 && d == 8'hf0) id_mode = 0;
      end
      1: st = u2 ? 2 : 0;
      2: begin
        st = (c && d == 8'ha0) ? 3 : (c && d == 8'h80) ? 4 : 0;
        if (c && d == 8'h90) id_mode = 1;
        if (c && d == 8'hf0) id_mode = 0;
      end
      3: begin
        st = 0;
        // Locked boot bytes and low supply refuse the program
        if (!(locked && a <= 19'h03fff) && !low_vcc) begin
          mem[a] = mem[a] & d;
          ld = d;
          busy_until = $time + PROG_NS;
        end
      end
      4: st = u1 ? 5 : 0;
      5: st = u2 ? 6 : 0;
      default: begin
        st = 0;
        if (c && d == 8'h10) begin
          foreach (mem[i]) if (!(locked && i <= 16'h3fff)) mem[i] = 8'hff;
          ld = 8'hff;
          busy_until = $time + ERASE_NS;
        end
        if (c && d == 8'h40) locked = 1;
      end
    endcase
  endtask
  // Read: codes in identification mode, status while busy, array otherwise
  always @(posedge rd) begin
    vld = 0;
    if ($time < busy_until) tog = ~tog;
    if (id_mode) rd_val = (addr == 19'h2) ? {7'h00, locked} : addr[0] ? DEV_CODE : MAKER_CODE;
    else if ($time < busy_until) rd_val = {~ld[7], tog, ld[5:0]};
    else rd_val = mem[addr];
    #ACC_NS vld = rd;
  end
endmodule

/* File: parallel_flash_command_engine_bench.sv */
// Self-checking bench for the flash host controller against the flash model.
// Assumes the controller finishes every operation with one DONE pulse.
module parallel_flash_command_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, NRST, START, BUSY, DONE, ERROR, CE_N, OE_N, WE_N, DATA_LINES_OE, flash_oe;
  logic [2:0]  OP;
  logic [18:0] ADDRESS, BYTE_ADDRESS;
  logic [7:0]  WDATA, RDATA, DATA_LINES_O, flash_dq, bus_dq;
  int          wr_count, num_errors, n_checks, took, n0;
  assign bus_dq = DATA_LINES_OE ? DATA_LINES_O : flash_dq;  // Resolved data lines
  flash_host_ctrl DUT (.CLK(CLK), .NRST(NRST), .START(START), .OP(OP), .ADDRESS(ADDRESS),
    .WDATA(WDATA), .BUSY(BUSY), .DONE(DONE), .ERROR(ERROR), .RDATA(RDATA), .CE_N(CE_N),
    .OE_N(OE_N), .WE_N(WE_N), .BYTE_ADDRESS(BYTE_ADDRESS), .DATA_LINES_I(bus_dq),
    .DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE(DATA_LINES_OE));
  flash_model flash (.ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .addr(BYTE_ADDRESS),
    .dq_in(bus_dq), .dq_out(flash_dq), .dq_oe(flash_oe), .wr_count(wr_count));
  // 40 MHz clock
  initial begin
    CLK = 0;
    forever #12.5 CLK = ~CLK;
  end
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One operation; poke tries a second START while busy
  task run(input logic [2:0] o, input logic [18:0] a, input logic [7:0] d, input bit poke);
    @(negedge CLK); START = 1; OP = o; ADDRESS = a; WDATA = d;
    @(negedge CLK); START = 0;
    if (poke) begin
      @(negedge CLK); START = 1; OP = flash_host_pkg::OP_ERASE;
      @(negedge CLK); START = 0;
    end
    took = 0;
    while (DONE !== 1'b1 && took < 20000) begin @(negedge CLK); took++; end
    check(DONE, 1'b1);
  endtask
  // Strobes idle and bus released while reset is held
  task t_reset;
    check({CE_N, OE_N, WE_N, BUSY, DATA_LINES_OE}, 5'b11100);
  endtask
  // Program, refused START, clear-only programming
  task t_program;
    n0 = wr_count;
    run(flash_host_pkg::OP_PROGRAM, 19'h12345, 8'h5a, 1);
    check(wr_count - n0, 4);
    check(ERROR, 1'b0);
    check(took >= 1990, 1);
    run(flash_host_pkg::OP_READ, 19'h12345, 8'h00, 0);
    check(RDATA, 8'h5a);
    run(flash_host_pkg::OP_PROGRAM, 19'h12345, 8'h7e, 0);
    run(flash_host_pkg::OP_READ, 19'h12345, 8'h00, 0);
    check(RDATA, 8'h5a);
    run(flash_host_pkg::OP_PROGRAM, 19'h00100, 8'h11, 0);
  endtask
  // Identification entry, lockout status, maker code and exit
  task t_ident;
    run(flash_host_pkg::OP_ID_READ, 19'h00002, 8'h00, 0);
    check(RDATA, 8'h00);
    run(flash_host_pkg::OP_ID_READ, 19'h00000, 8'h00, 0);
    check(RDATA, 8'h3c);
    run(flash_host_pkg::OP_ID_EXIT, 19'h00000, 8'h00, 0);
    run(flash_host_pkg::OP_READ, 19'h12345, 8'h00, 0);
    check(RDATA, 8'h5a);
  endtask
  // Lockout, refused boot program, main area still programmable
  task t_lock;
    n0 = wr_count;
    run(flash_host_pkg::OP_LOCKOUT, 19'h00000, 8'h00, 0);
    check(wr_count - n0, 6);
    run(flash_host_pkg::OP_ID_READ, 19'h00002, 8'h00, 0);
    check(RDATA, 8'h01);
    run(flash_host_pkg::OP_ID_EXIT, 19'h00000, 8'h00, 0);
    // Refused boot program never shows true bit seven, so the poll runs out
    run(flash_host_pkg::OP_PROGRAM, 19'h00100, 8'h80, 0);
    check(ERROR, 1'b1);
    check(took >= flash_host_pkg::PROG_TIMEOUT_CYC, 1);
    run(flash_host_pkg::OP_READ, 19'h00100, 8'h00, 0);
    check(RDATA, 8'h11);
    run(flash_host_pkg::OP_PROGRAM, 19'h20000, 8'h3c, 0);
    run(flash_host_pkg::OP_READ, 19'h20000, 8'h00, 0);
    check(RDATA, 8'h3c);
  endtask
  // Chip erase spares the locked boot block
  task t_erase;
    n0 = wr_count;
    run(flash_host_pkg::OP_ERASE, 19'h00000, 8'h00, 0);
    check(wr_count - n0, 6);
    check(ERROR, 1'b0);
    run(flash_host_pkg::OP_READ, 19'h20000, 8'h00, 0);
    check(RDATA, 8'hff);
    run(flash_host_pkg::OP_READ, 19'h00100, 8'h00, 0);
    check(RDATA, 8'h11);
  endtask
  // No contention on the data lines
  always @(negedge CLK) if (NRST === 1'b1 && flash_oe && DATA_LINES_OE) check(1, 0);
  // Watchdog
  initial begin
    #(60000 * 25);
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    NRST = 0; START = 0; OP = 3'h0; ADDRESS = '0; WDATA = 8'h00;
    num_errors = 0; n_checks = 0;
    repeat (4) @(negedge CLK);
    t_reset();
    NRST = 1;
    t_program();
    t_ident();
    t_lock();
    t_erase();
    print_verdict();
  end
endmodule
